// >>> asr_host.sv
/*
  asr_host: host controller for an asynchronous 128k x 8 static memory. takes
  one read or write request at a time and drives address, strobes and data.
  assumes the memory pins are registered outputs and dq_in is synchronous.
*/
// Operation
// - write enable held high during reads
// - address valid before select falls; the host moves both on one edge
// - address valid before write window ends
// - write data set up before window ends
// - output enable low stretches write pulse
// - output enable high: plain write pulse
// - select held through whole write period
// - host never drives while memory drives
`timescale 1ns/1ns
module asr_host
#(
  parameter int GRADE = 2
)
(
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         nrst,
  // request side
  input  wire logic                         req_valid,
  output logic                              req_ready,
  input  wire asr_pkg::asr_req_s            req,
  output logic                              rsp_valid,
  output logic [asr_pkg::ASR_DW-1:0]        rsp_rdata,
  // memory pins
  output asr_pkg::asr_pins_s                pins,
  input  wire logic [asr_pkg::ASR_DW-1:0]   dq_in
);

  // larger of two figures in ns
  function automatic int ns_max
  (
    input int a,
    input int b
  );
    return (a > b) ? a : b;
  endfunction

  // read holds until both select and output enable access times pass
  localparam int RD_NS   = ns_max(asr_pkg::ASR_T_RC[GRADE], asr_pkg::ASR_T_OE[GRADE]);
  // output enable stays high in writes, so the plain pulse width suffices
  localparam int WP_NS   = ns_max(ns_max(asr_pkg::ASR_T_WP[GRADE], asr_pkg::ASR_T_AW[GRADE]),
                                  asr_pkg::ASR_T_DW[GRADE]);
  // turnaround covers the deselect float time before anyone drives again
  localparam int REC_NS  = ns_max(asr_pkg::ASR_T_CHZ[GRADE], asr_pkg::ASR_T_OW[GRADE]);
  localparam int RD_CYC  = asr_pkg::asr_cyc_min(RD_NS);
  localparam int WP_CYC  = asr_pkg::asr_cyc_min(WP_NS);
  localparam int REC_CYC = asr_pkg::asr_cyc_min(REC_NS);
  // writes count their entry edge; reads keep a spare cycle for sampling
  localparam logic [asr_pkg::ASR_CNT_W-1:0] RD_LOAD  = 4'(RD_CYC);
  localparam logic [asr_pkg::ASR_CNT_W-1:0] WP_LOAD  = 4'(WP_CYC - 1);
  localparam logic [asr_pkg::ASR_CNT_W-1:0] REC_LOAD = 4'(REC_CYC - 1);

  asr_pkg::asr_state_e           state_reg;
  asr_pkg::asr_state_e           state_next;
  logic [asr_pkg::ASR_DW-1:0]    wdata_reg;
  asr_pkg::asr_pins_s            pins_reg;
  asr_pkg::asr_pins_s            pins_next;
  logic [asr_pkg::ASR_DW-1:0]    rdata_reg;
  logic [asr_pkg::ASR_DW-1:0]    rdata_next;
  logic                          is_wr_reg;

  logic                          tmr_load;
  logic [asr_pkg::ASR_CNT_W-1:0] tmr_count;
  logic                          tmr_done;
  logic                          take;
  logic                          in_idle;
  logic                          in_rd;
  logic                          in_wr;
  logic                          in_rec;
  logic                          in_done;
  logic                          rd_end;
  logic                          wr_end;
  logic                          rec_end;
  asr_pkg::asr_pins_s            start_pins;
  logic [asr_pkg::ASR_CNT_W-1:0] start_load;

  assign in_idle    = (state_reg == asr_pkg::ASR_IDLE);
  assign in_rd      = (state_reg == asr_pkg::ASR_RD);
  assign in_wr      = (state_reg == asr_pkg::ASR_WR);
  assign in_rec     = (state_reg == asr_pkg::ASR_REC);
  assign in_done    = (state_reg == asr_pkg::ASR_DONE);
  assign rd_end     = in_rd && tmr_done;
  assign wr_end     = in_wr && tmr_done;
  assign rec_end    = in_rec && tmr_done;

  assign req_ready  = in_idle;
  assign take       = req_valid && req_ready;
  assign rsp_valid  = in_done;
  assign rsp_rdata  = rdata_reg;
  assign pins       = pins_reg;

  // a new cycle drops select with address, data and strobes on one edge
  assign start_pins = '{cs_n:   1'b0,
                        oe_n:   req.write,
                        we_n:   !req.write,
                        addr:   req.addr,
                        dq_out: req.wdata,
                        dq_oe:  req.write};

  assign start_load = req.write ? WP_LOAD : RD_LOAD;

  // a write echoes its byte one edge after the response pulse
  assign rdata_next = rd_end                 ? dq_in :
                      (in_done && is_wr_reg) ? wdata_reg :
                      rdata_reg;

  asr_timer u_timer
  (
    .clk     (clk),
    .nrst    (nrst),
    .load    (tmr_load),
    .count   (tmr_count),
    .expired (tmr_done)
  );

  always_comb
  begin
    state_next = state_reg;
    pins_next  = pins_reg;
    tmr_load   = 1'b0;
    tmr_count  = 4'h0;
    unique case (state_reg)
      asr_pkg::ASR_IDLE:
      begin
        if (take)
        begin
          pins_next  = start_pins;
          tmr_load   = 1'b1;
          tmr_count  = start_load;
          state_next = req.write ? asr_pkg::ASR_WR : asr_pkg::ASR_RD;
        end
      end
      asr_pkg::ASR_RD:
      begin
        // one spare cycle for the registered sample of dq_in
        if (rd_end)
        begin
          pins_next.cs_n = 1'b1;
          pins_next.oe_n = 1'b1;
          tmr_load   = 1'b1;
          tmr_count  = REC_LOAD;
          state_next = asr_pkg::ASR_REC;
        end
      end
      asr_pkg::ASR_WR:
      begin
        // data held with address one edge past the window end: zero hold
        if (wr_end)
        begin
          pins_next.cs_n = 1'b1;
          pins_next.we_n = 1'b1;
          tmr_load   = 1'b1;
          tmr_count  = REC_LOAD;
          state_next = asr_pkg::ASR_REC;
        end
      end
      asr_pkg::ASR_REC:
      begin
        pins_next.dq_oe = 1'b0;
        if (rec_end)
          state_next = asr_pkg::ASR_DONE;
      end
      asr_pkg::ASR_DONE:
      begin
        state_next = asr_pkg::ASR_IDLE;
      end
    endcase
  end

  // sequencer state and registered pins
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_reg <= asr_pkg::ASR_IDLE;
      pins_reg  <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};
    end
    else
    begin
      state_reg <= state_next;
      pins_reg  <= pins_next;
    end
  end

  // request copy and answer byte; dq_in is taken only at the end of a read
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rdata_reg <= 8'h00;
      is_wr_reg <= 1'b0;
      wdata_reg <= 8'h00;
    end
    else
    begin
      rdata_reg <= rdata_next;
      if (take)
      begin
        is_wr_reg <= req.write;
        wdata_reg <= req.wdata;
      end
    end
  end

endmodule

// >>> asr_mem_model.sv
/*
  asr_mem_model: behavioural 128k x 8 static memory at the host's pins.
  assumes pins come from the host and dq feeds its dq_in.
*/
`timescale 1ns/1ns
module asr_mem_model
#(
  parameter int T_ACC = 20
)
(
  // host pins
  input  wire asr_pkg::asr_pins_s pins,
  // data seen by host
  output logic [7:0]              dq
);
  logic [7:0] mem [131072];
  logic [7:0] late;
  // no clock: level write while select and enable overlap
  always @*
    if (!pins.cs_n && !pins.we_n && pins.dq_oe)
      mem[pins.addr] = pins.dq_out;
  // slow answer: old data stands until access time runs out
  assign #(T_ACC) late = mem[pins.addr];
  // released bus shows the inverse, never the last value
  assign dq = (!pins.cs_n && !pins.oe_n && pins.we_n) ? late : ~late;
endmodule

// >>> asr_pkg.sv
/*
  asr_pkg: constants and carrier types for the asynchronous 128k x 8 static
  memory host controller. assumes a 250 mhz clock and the slowest speed grade
  timing unless a faster grade is selected at the top.
*/
package asr_pkg;

  localparam int ASR_AW    = 17;
  localparam int ASR_DW    = 8;
  localparam int ASR_CLK_PS = 4000;

  // speed grade figures in ns: index 0 = 12, 1 = 15, 2 = 20 ns grade
  localparam int ASR_T_RC   [3] = '{12, 15, 20};
  localparam int ASR_T_OE   [3] = '{6, 7, 8};
  localparam int ASR_T_CHZ  [3] = '{6, 7, 8};
  localparam int ASR_T_AW   [3] = '{8, 12, 15};
  localparam int ASR_T_WP   [3] = '{8, 12, 15};
  localparam int ASR_T_DW   [3] = '{6, 8, 9};
  localparam int ASR_T_WHZ  [3] = '{5, 5, 8};
  localparam int ASR_T_OW   [3] = '{3, 3, 4};
  localparam int ASR_T_OH   = 4;

  // least time rounds up, at least one cycle
  function automatic int asr_cyc_min(input int ns);
    int c;
    c = (ns * 1000 + ASR_CLK_PS - 1) / ASR_CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int ASR_CNT_W = 4;

  typedef enum logic [4:0] {
    ASR_IDLE  = 5'h01,
    ASR_RD    = 5'h02,
    ASR_WR    = 5'h04,
    ASR_REC   = 5'h08,
    ASR_DONE  = 5'h10
  } asr_state_e;

  typedef struct packed {
    logic              write;
    logic [ASR_AW-1:0] addr;
    logic [ASR_DW-1:0] wdata;
  } asr_req_s;

  typedef struct packed {
    logic              cs_n;
    logic              oe_n;
    logic              we_n;
    logic [ASR_AW-1:0] addr;
    logic [ASR_DW-1:0] dq_out;
    logic              dq_oe;
  } asr_pins_s;

endpackage

// >>> asr_properties.sv
/*
  asr_properties: pin timing checks of the memory host, grade 2 counts.
  assumes a bind to asr_host at its default grade with a 4 ns clock.
*/
`timescale 1ns/1ns
module asr_properties
(
  // clock and reset
  input wire logic               clk,
  input wire logic               nrst,
  // request side
  input wire logic               req_valid,
  input wire logic               req_ready,
  input wire asr_pkg::asr_req_s  req,
  input wire logic               rsp_valid,
  // memory pins
  input wire asr_pkg::asr_pins_s pins
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_read_we_high:
    assert property (!pins.oe_n |-> pins.we_n) else $error("oe and we low together");
  a_addr_stable:
    assert property (!pins.cs_n && !$past(pins.cs_n) |-> $stable(pins.addr)) else $error("addr moved");
  a_write_pulse:
    assert property ($fell(pins.we_n) |-> (!pins.we_n && !pins.cs_n)[*4] ##1 (pins.we_n && pins.cs_n))
      else $error("write pulse length");
  a_write_data:
    assert property (!pins.we_n |-> pins.dq_oe && ($fell(pins.we_n) || $stable(pins.dq_out)))
      else $error("write data unsettled");
  a_sel_with_we:
    assert property ($fell(pins.we_n) |-> $fell(pins.cs_n)) else $error("select not with we");
  a_no_contend:
    assert property (!pins.oe_n || !$past(pins.oe_n) |-> !pins.dq_oe) else $error("bus contention");
  a_read_time:
    assert property ($fell(pins.oe_n) |-> (!pins.oe_n && !pins.cs_n)[*6] ##1 pins.oe_n)
      else $error("read strobe length");
  a_rd_latency:
    assert property (req_valid && req_ready && !req.write |-> ##[9:10] rsp_valid) else $error("read latency");
endmodule
bind asr_host asr_properties i_props (.clk(clk), .nrst(nrst), .req_valid(req_valid),
  .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .pins(pins));

// >>> asr_timer.sv
/*
  asr_timer: down counter that marks when a phase of a memory cycle has lasted
  its minimum length. assumes load and the count come from the sequencer.
*/
`timescale 1ns/1ns
module asr_timer
(
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          nrst,
  // control
  input  wire logic                          load,
  input  wire logic [asr_pkg::ASR_CNT_W-1:0] count,
  // status
  output logic                               expired
);

  logic [asr_pkg::ASR_CNT_W-1:0] cnt_reg;
  logic [asr_pkg::ASR_CNT_W-1:0] cnt_next;

  assign cnt_next = load ? count : (cnt_reg != '0) ? cnt_reg - 4'h1 : cnt_reg;
  // no load term: the sequencer reloads on expiry, which would close a loop
  assign expired  = (cnt_reg == '0);

  always_ff @(posedge clk)
  begin
    if (!nrst)
      cnt_reg <= 4'h0;
    else
      cnt_reg <= cnt_next;
  end

endmodule

// >>> tb.sv
/*
  tb: self-checking bench of the memory host against a memory model.
  assumes grade 2 timing and a 250 mhz clock.
*/
`timescale 1ns/1ns
module tb;
  logic               clk = 1'b0;
  logic               nrst = 1'b0;
  logic               req_valid = 1'b0;
  asr_pkg::asr_req_s  req = '0;
  logic               req_ready;
  logic               rsp_valid;
  logic [7:0]         rsp_rdata;
  asr_pkg::asr_pins_s pins;
  logic [7:0]         dq_in;
  int                 num_errors = 0;
  int                 num_checks = 0;
  int                 cycles = 0;

  always #2 clk = ~clk;
  asr_host i_dut (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .pins(pins), .dq_in(dq_in));
  asr_mem_model i_mem (.pins(pins), .dq(dq_in));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // request held until taken, then answer awaited
  task automatic do_op(input logic wr, input logic [16:0] a, input logic [7:0] d, output logic [7:0] r);
    int n;
    req_valid <= 1'b1;
    req <= '{write: wr, addr: a, wdata: d};
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rsp_valid !== 1'b1 && n < 20);
    check("rsp_valid", 32'h1, {31'h0, rsp_valid});
    // the write echo lands one edge after the pulse
    if (wr)
      @(posedge clk);
    r = rsp_rdata;
  endtask

  task automatic t_reset();
    check("pins", 32'h1c000000, {3'h0, pins});
    check("req_ready", 32'h1, {31'h0, req_ready});
    check("rsp_rdata", 32'h0, {24'h0, rsp_rdata});
    $display("test reset done");
  endtask

  // top and bottom addresses and one differing only in bit 16
  task automatic t_span();
    logic [16:0] a [4] = '{17'h00000, 17'h1ffff, 17'h10000, 17'h0aa55};
    logic [7:0]  d [4] = '{8'h11, 8'hee, 8'h5a, 8'ha5};
    logic [7:0]  r;
    foreach (a[i])
    begin
      do_op(1'b1, a[i], d[i], r);
      check("echo", {24'h0, d[i]}, {24'h0, r});
    end
    foreach (a[i])
    begin
      do_op(1'b0, a[i], 8'h00, r);
      check("rdata", {24'h0, d[i]}, {24'h0, r});
    end
    $display("test span done");
  endtask

  task automatic t_overwrite();
    logic [7:0] r;
    do_op(1'b1, 17'h10000, 8'h96, r);
    do_op(1'b0, 17'h10000, 8'h00, r);
    check("rdata", 32'h96, {24'h0, r});
    do_op(1'b0, 17'h00000, 8'h00, r);
    check("rdata", 32'h11, {24'h0, r});
    $display("test overwrite done");
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      complete_run();
    end
  end

  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_span();
    t_overwrite();
    complete_run();
  end
endmodule
